/* design/debug_compare_trace_regs.sv */
module debug_compare_trace_regs (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic clk_en_i,
  input wire logic [dbg_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [dbg_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic serial_access_i,
  output logic [dbg_pkg::DATA_W-1:0] reg_rdata_o,
  input wire logic secure_i,
  input wire logic [dbg_pkg::CPU_ADDR_W-1:0] cpu_addr_i,
  input wire logic [dbg_pkg::DATA_W-1:0] cpu_data_i,
  input wire logic cpu_valid_i,
  input wire logic cpu_read_i,
  input wire logic opcode_fetch_i,
  input wire logic [3:0] trigger_mode_i,
  input wire logic begin_trace_i,
  input wire logic opcode_qualified_trigger_i,
  output logic armed_flag_o,
  output logic [dbg_pkg::CNT_W-1:0] valid_count_o,
  output logic break_request_o,
  output logic break_tag_o,
  output logic mcu_reset_o
);
  import dbg_pkg::*;

  logic [DATA_W-1:0] cmp_a_high_q;
  logic [DATA_W-1:0] cmp_a_low_q;
  logic [DATA_W-1:0] cmp_b_high_q;
  logic [DATA_W-1:0] cmp_b_low_q;
  logic module_enable_q;
  logic armed_q;
  logic tag_q;
  logic break_enable_q;
  logic cmp_a_direction_q;
  logic cmp_a_direction_en_q;
  logic cmp_b_direction_q;
  logic cmp_b_direction_en_q;
  logic [CPU_ADDR_W-1:0] last_opcode_q;
  logic a_seen_q;
  logic [CNT_W-1:0] count_q;
  run_state_t state_q;
  run_state_t state_d;
  logic [DATA_W-1:0] rdata_q;
  logic break_q;
  logic reset_q;

  logic wr_cmp_ok;
  logic wr_ctrl;
  logic arm_start;
  logic event_mode;
  logic begin_mode;
  logic [CPU_ADDR_W-1:0] cmp_a;
  logic [CPU_ADDR_W-1:0] cmp_b;
  logic qual;
  logic a_hit;
  logic b_hit;
  logic a_match;
  logic b_match;
  logic trigger;
  logic capture;
  logic [TRACE_W-1:0] capture_data;
  logic run_done;
  logic low_read;
  logic shift;
  logic [TRACE_W-1:0] shift_data;
  logic [TRACE_W-1:0] head;

  assign cmp_a = {cmp_a_high_q, cmp_a_low_q};
  assign cmp_b = {cmp_b_high_q, cmp_b_low_q};

  // the nine-byte map: four comparator bytes, two trace ports, control,
  // plus force reset at offset 8, with offset 7 left to the neighbouring logic
  assign wr_cmp_ok = reg_wr_i && !armed_q;
  assign wr_ctrl = reg_wr_i && (reg_addr_i == OFF_DEBUG_CONTROL);
  assign arm_start = wr_ctrl && reg_wdata_i[BIT_ARMED] && reg_wdata_i[BIT_MODULE_ENABLE]
    && (module_enable_q || !secure_i) && !armed_q;

  assign event_mode = (trigger_mode_i == TRG_EVENT_B) || (trigger_mode_i == TRG_A_THEN_EVENT_B);
  // event-only runs are always begin traces
  assign begin_mode = begin_trace_i || event_mode;

  // comparators with direction qualifiers
  // opcode-qualified triggers here only count matches on opcode fetch cycles
  assign qual = cpu_valid_i && (!opcode_qualified_trigger_i || opcode_fetch_i);
  assign a_hit = !cmp_a_direction_en_q || (cpu_read_i == cmp_a_direction_q);
  assign b_hit = !cmp_b_direction_en_q || (cpu_read_i == cmp_b_direction_q);
  assign a_match = qual && a_hit && (cpu_addr_i == cmp_a);
  assign b_match = qual && b_hit && (cpu_addr_i == cmp_b);

  always_comb begin
    trigger = 1'b0;
    case (trigger_mode_i)
      TRG_A_ONLY: trigger = a_match;
      TRG_A_OR_B: trigger = a_match || b_match;
      TRG_A_THEN_B: trigger = a_seen_q && b_match;
      TRG_EVENT_B: trigger = b_match;
      TRG_A_THEN_EVENT_B: trigger = a_match || (a_seen_q && b_match);
      TRG_A_AND_B: trigger = a_match && (cpu_data_i == cmp_b_low_q);
      TRG_A_AND_NOT_B: trigger = a_match && (cpu_data_i != cmp_b_low_q);
      TRG_INSIDE: trigger = qual && a_hit && (cpu_addr_i >= cmp_a) && (cpu_addr_i <= cmp_b);
      TRG_OUTSIDE: trigger = qual && a_hit && ((cpu_addr_i < cmp_a) || (cpu_addr_i > cmp_b));
      default: trigger = 1'b0;
    endcase
  end

  // what goes into the buffer while armed
  always_comb begin
    capture = 1'b0;
    capture_data = {cpu_addr_i};
    if (event_mode) begin
      capture_data = {READ_ZERO, cpu_data_i};
      capture = (state_q == RUN_FILL) && b_match && (trigger_mode_i == TRG_EVENT_B || a_seen_q);
    end else if (state_q == RUN_WAIT) begin
      capture = !begin_mode && cpu_valid_i && opcode_fetch_i;
    end else if (state_q == RUN_FILL) begin
      capture = cpu_valid_i && opcode_fetch_i;
    end
  end

  // run sequencing
  always_comb begin
    state_d = state_q;
    run_done = 1'b0;
    case (state_q)
      RUN_IDLE: begin
        if (arm_start) begin
          state_d = RUN_WAIT;
        end
      end
      RUN_WAIT: begin
        if (trigger) begin
          if (begin_mode) begin
            state_d = RUN_FILL;
          end else begin
            run_done = 1'b1;
            state_d = RUN_IDLE;
          end
        end
      end
      RUN_FILL: begin
        if (capture && (count_q == CNT_FULL - 4'h1)) begin
          run_done = 1'b1;
          state_d = RUN_IDLE;
        end
      end
      default: state_d = RUN_IDLE;
    endcase
    // a manual stop wins over every state transition; run_done, and so the break pulse, can still fire in that cycle
    if (wr_ctrl && (!reg_wdata_i[BIT_ARMED] || !reg_wdata_i[BIT_MODULE_ENABLE])) begin
      state_d = RUN_IDLE;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_q <= RUN_IDLE;
    end else if (clk_en_i) begin
      state_q <= state_d;
    end
  end

  // comparator bytes
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      cmp_a_high_q <= RST_CMP;
      cmp_a_low_q <= RST_CMP;
      cmp_b_high_q <= RST_CMP;
      cmp_b_low_q <= RST_CMP;
    end else if (clk_en_i && wr_cmp_ok) begin
      case (reg_addr_i)
        OFF_CMP_A_HIGH: cmp_a_high_q <= reg_wdata_i;
        OFF_CMP_A_LOW: cmp_a_low_q <= reg_wdata_i;
        OFF_CMP_B_HIGH: cmp_b_high_q <= reg_wdata_i;
        OFF_CMP_B_LOW: cmp_b_low_q <= reg_wdata_i;
        default: ;
      endcase
    end
  end

  // control register
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      {module_enable_q, tag_q, break_enable_q} <= RST_DEBUG_CONTROL[2:0];
      {cmp_a_direction_q, cmp_a_direction_en_q} <= RST_DEBUG_CONTROL[1:0];
      {cmp_b_direction_q, cmp_b_direction_en_q} <= RST_DEBUG_CONTROL[1:0];
    end else if (clk_en_i && wr_ctrl) begin
      // secured part keeps the enable from rising
      module_enable_q <= reg_wdata_i[BIT_MODULE_ENABLE] && (module_enable_q || !secure_i);
      tag_q <= reg_wdata_i[BIT_TAG];
      break_enable_q <= reg_wdata_i[BIT_BREAK_ENABLE];
      cmp_a_direction_q <= reg_wdata_i[BIT_CMP_A_DIRECTION];
      cmp_a_direction_en_q <= reg_wdata_i[BIT_CMP_A_DIRECTION_EN];
      cmp_b_direction_q <= reg_wdata_i[BIT_CMP_B_DIRECTION];
      cmp_b_direction_en_q <= reg_wdata_i[BIT_CMP_B_DIRECTION_EN];
    end
  end

  // armed bit mirrors the run state, doubles as the arm flag
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      armed_q <= 1'b0;
    end else if (clk_en_i) begin
      armed_q <= (state_d != RUN_IDLE);
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      a_seen_q <= 1'b0;
    end else if (clk_en_i) begin
      if (arm_start) begin
        a_seen_q <= 1'b0;
      end else if (armed_q && a_match) begin
        a_seen_q <= 1'b1;
      end
    end
  end

  // valid count saturates at full, kept after the run
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      count_q <= CNT_ZERO;
    end else if (clk_en_i) begin
      if (arm_start) begin
        count_q <= CNT_ZERO;
      end else if (capture && count_q != CNT_FULL) begin
        count_q <= count_q + 4'h1;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      last_opcode_q <= '0;
    end else if (clk_en_i && cpu_valid_i && opcode_fetch_i) begin
      last_opcode_q <= cpu_addr_i;
    end
  end

  // buffer shifting: capture while armed, profiling reads otherwise
  assign low_read = reg_rd_i && (reg_addr_i == OFF_TRACE_LOW);
  assign shift = armed_q ? capture : low_read;
  assign shift_data = armed_q ? capture_data : last_opcode_q;

  // eight entries make the ninth profiling read return the first capture
  trace_shift_buffer #(
    .WIDTH(TRACE_W),
    .DEPTH(TRACE_DEPTH)
  ) u_trace (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .clk_en_i(clk_en_i),
    .shift_i(shift),
    .in_data_i(shift_data),
    .head_o(head)
  );

  // read data registered, answer one cycle after the strobe
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rdata_q <= READ_ZERO;
    end else if (clk_en_i && reg_rd_i) begin
      case (reg_addr_i)
        OFF_CMP_A_HIGH: rdata_q <= cmp_a_high_q;
        OFF_CMP_A_LOW: rdata_q <= cmp_a_low_q;
        OFF_CMP_B_HIGH: rdata_q <= cmp_b_high_q;
        OFF_CMP_B_LOW: rdata_q <= cmp_b_low_q;
        OFF_TRACE_HIGH: rdata_q <= event_mode ? READ_ZERO : head[15:8];
        OFF_TRACE_LOW: rdata_q <= head[7:0];
        OFF_DEBUG_CONTROL: rdata_q <= {module_enable_q, armed_q, tag_q, break_enable_q,
          cmp_a_direction_q, cmp_a_direction_en_q, cmp_b_direction_q, cmp_b_direction_en_q};
        OFF_FORCE_RESET: rdata_q <= READ_ZERO;
        default: rdata_q <= READ_ZERO;
      endcase
    end
  end

  // break pulse: trigger for end trace, full for begin trace
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      break_q <= 1'b0;
    end else if (clk_en_i) begin
      break_q <= break_enable_q && run_done;
    end
  end

  // only the serial debug path can reach the force reset bit
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      reset_q <= 1'b0;
    end else if (clk_en_i) begin
      reset_q <= reg_wr_i && serial_access_i && (reg_addr_i == OFF_FORCE_RESET)
        && reg_wdata_i[BIT_FORCE_RESET];
    end
  end

  assign reg_rdata_o = rdata_q;
  assign armed_flag_o = armed_q;
  assign valid_count_o = count_q;
  assign break_request_o = break_q;
  assign break_tag_o = break_q && tag_q;
  assign mcu_reset_o = reset_q;

endmodule : debug_compare_trace_regs

/* design/dbg_pkg.sv */
package dbg_pkg;

  // register port
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int CPU_ADDR_W = 16;
  localparam logic [ADDR_W-1:0] OFF_CMP_A_HIGH = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_CMP_A_LOW = 4'h1;
  localparam logic [ADDR_W-1:0] OFF_CMP_B_HIGH = 4'h2;
  localparam logic [ADDR_W-1:0] OFF_CMP_B_LOW = 4'h3;
  localparam logic [ADDR_W-1:0] OFF_TRACE_HIGH = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_TRACE_LOW = 4'h5;
  localparam logic [ADDR_W-1:0] OFF_DEBUG_CONTROL = 4'h6;
  localparam logic [ADDR_W-1:0] OFF_FORCE_RESET = 4'h8;

  // debug_control fields
  localparam int BIT_MODULE_ENABLE = 7;
  localparam int BIT_ARMED = 6;
  localparam int BIT_TAG = 5;
  localparam int BIT_BREAK_ENABLE = 4;
  localparam int BIT_CMP_A_DIRECTION = 3;
  localparam int BIT_CMP_A_DIRECTION_EN = 2;
  localparam int BIT_CMP_B_DIRECTION = 1;
  localparam int BIT_CMP_B_DIRECTION_EN = 0;
  localparam int BIT_FORCE_RESET = 0;

  // reset values
  localparam logic [DATA_W-1:0] RST_CMP = 8'h00;
  localparam logic [DATA_W-1:0] RST_DEBUG_CONTROL = 8'h00;
  localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;

  // trace buffer
  localparam int TRACE_W = 16;
  localparam int TRACE_DEPTH = 8;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] CNT_FULL = 4'h8;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;

  // trigger mode codes
  localparam logic [3:0] TRG_A_ONLY = 4'h0;
  localparam logic [3:0] TRG_A_OR_B = 4'h1;
  localparam logic [3:0] TRG_A_THEN_B = 4'h2;
  localparam logic [3:0] TRG_EVENT_B = 4'h3;
  localparam logic [3:0] TRG_A_THEN_EVENT_B = 4'h4;
  localparam logic [3:0] TRG_A_AND_B = 4'h5;
  localparam logic [3:0] TRG_A_AND_NOT_B = 4'h6;
  localparam logic [3:0] TRG_INSIDE = 4'h7;
  localparam logic [3:0] TRG_OUTSIDE = 4'h8;

  typedef enum logic [1:0] {
    RUN_IDLE = 2'b00,
    RUN_WAIT = 2'b01,
    RUN_FILL = 2'b11
  } run_state_t;

endpackage : dbg_pkg

/* design/trace_shift_buffer.sv */
module trace_shift_buffer #(
  parameter int WIDTH = dbg_pkg::TRACE_W,
  parameter int DEPTH = dbg_pkg::TRACE_DEPTH
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic clk_en_i,
  input wire logic shift_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic [WIDTH-1:0] head_o
);
  import dbg_pkg::*;

  // entry 0 is the oldest word, new words enter at the last entry
  logic [WIDTH-1:0] entry_q [DEPTH];

  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_entry
      always_ff @(posedge clock_i) begin
        if (rst_i) begin
          entry_q[g] <= '0;
        end else if (clk_en_i && shift_i) begin
          if (g == DEPTH - 1) begin
            entry_q[g] <= in_data_i;
          end else begin
            entry_q[g] <= entry_q[g+1];
          end
        end
      end
    end
  endgenerate

  assign head_o = entry_q[0];

endmodule : trace_shift_buffer

/* dv/debug_compare_trace_regs_properties.sv */
module debug_compare_trace_regs_checker (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic clk_en_i,
  input wire logic [dbg_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [dbg_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic serial_access_i,
  input wire logic [dbg_pkg::DATA_W-1:0] reg_rdata_o,
  input wire logic [3:0] trigger_mode_i,
  input wire logic armed_flag_o,
  input wire logic [dbg_pkg::CNT_W-1:0] valid_count_o,
  input wire logic break_request_o,
  input wire logic break_tag_o,
  input wire logic mcu_reset_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import dbg_pkg::*;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  logic fr_wr;
  logic ctl_wr;
  logic arm_wr;
  logic ev_mode;
  assign fr_wr = clk_en_i && reg_wr_i && serial_access_i && reg_addr_i == OFF_FORCE_RESET && reg_wdata_i[BIT_FORCE_RESET];
  assign ctl_wr = clk_en_i && reg_wr_i && reg_addr_i == OFF_DEBUG_CONTROL;
  assign arm_wr = ctl_wr && reg_wdata_i[BIT_ARMED];
  assign ev_mode = trigger_mode_i == TRG_EVENT_B || trigger_mode_i == TRG_A_THEN_EVENT_B;
  chk_serial_reset: assert property (fr_wr |=> mcu_reset_o) else $error("reset pulse missing");
  chk_user_reset_ignored: assert property (mcu_reset_o |-> $past(fr_wr)) else $error("reset without serial");
  chk_reset_one_cycle: assert property (mcu_reset_o |=> !mcu_reset_o) else $error("reset pulse too long");
  chk_force_reads_zero: assert property (clk_en_i && reg_rd_i && reg_addr_i == OFF_FORCE_RESET
    |=> reg_rdata_o == READ_ZERO) else $error("force reset read nonzero");
  chk_event_high_zero: assert property (clk_en_i && reg_rd_i && reg_addr_i == OFF_TRACE_HIGH && ev_mode
    |=> reg_rdata_o == READ_ZERO) else $error("event high byte nonzero");
  chk_break_ends_run: assert property (break_request_o |-> !armed_flag_o && $past(armed_flag_o))
    else $error("break outside run end");
  chk_break_one_cycle: assert property (break_request_o |=> !break_request_o) else $error("break too long");
  chk_tag_with_break: assert property (break_tag_o |-> break_request_o) else $error("tag without break");
  chk_stop_at_once: assert property (ctl_wr && !reg_wdata_i[BIT_ARMED] |=> !armed_flag_o)
    else $error("run not stopped");
  chk_arm_by_write: assert property ($rose(armed_flag_o) |-> $past(arm_wr)) else $error("arm without write");
  chk_count_limit: assert property (valid_count_o <= CNT_FULL) else $error("count above full");
endmodule : debug_compare_trace_regs_checker

bind debug_compare_trace_regs debug_compare_trace_regs_checker u_chk (
  .clock_i(clock_i), .rst_i(rst_i), .clk_en_i(clk_en_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .serial_access_i(serial_access_i), .reg_rdata_o(reg_rdata_o),
  .trigger_mode_i(trigger_mode_i), .armed_flag_o(armed_flag_o), .valid_count_o(valid_count_o),
  .break_request_o(break_request_o), .break_tag_o(break_tag_o), .mcu_reset_o(mcu_reset_o)
);

/* dv/cpu_bus_model.sv */
module cpu_bus_model (
  input wire logic clock_i,
  input wire logic [1:0] mode_i,
  input wire logic [15:0] addr_i,
  input wire logic read_i,
  output logic [15:0] cpu_addr_o,
  output logic [7:0] cpu_data_o,
  output logic cpu_valid_o,
  output logic cpu_read_o,
  output logic opcode_fetch_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] pc_q = 16'h0100;
  initial begin
    cpu_addr_o = 16'h0000;
    cpu_valid_o = 1'b0;
    cpu_read_o = 1'b1;
    opcode_fetch_o = 1'b0;
  end
  // mode 1 free stream, 2 fixed address every cycle while held, 0 idle
  // idle bus inverts its address every cycle; cpu_valid_o stays low so a stale value can never match
  always @(posedge clock_i) begin
    if (mode_i == 2'h1) pc_q <= pc_q + 16'h0001;
    cpu_addr_o <= (mode_i == 2'h2) ? addr_i : (mode_i == 2'h1) ? pc_q : ~cpu_addr_o;
    cpu_read_o <= (mode_i == 2'h2) ? read_i : (mode_i == 2'h1) | ~cpu_read_o;
    opcode_fetch_o <= (mode_i == 2'h2) ? read_i : (mode_i == 2'h1) & pc_q[0];
    cpu_valid_o <= mode_i != 2'h0;
  end
  assign cpu_data_o = cpu_addr_o[7:0] ^ 8'h5A;
endmodule : cpu_bus_model

/* dv/debug_compare_trace_regs_tb.sv */
module debug_compare_trace_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import dbg_pkg::*;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic [ADDR_W-1:0] reg_addr_i = 4'h0;
  logic reg_wr_i = 1'b0, reg_rd_i = 1'b0, serial_access_i = 1'b0, secure_i = 1'b0, begin_trace_i = 1'b0;
  logic [DATA_W-1:0] reg_wdata_i = 8'h00, reg_rdata_o, cpu_data_i;
  logic [3:0] trigger_mode_i = TRG_A_ONLY;
  logic [1:0] cpu_mode = 2'h0;
  logic [15:0] sel_addr = 16'h0000, cpu_addr_i, a;
  logic sel_rd = 1'b0, cpu_valid_i, cpu_read_i, opcode_fetch_i, rd_pend = 1'b0;
  logic clk_en_i = 1'b1, opcode_qualified_trigger_i = 1'b0;
  logic armed_flag_o, break_request_o, break_tag_o, mcu_reset_o;
  logic [CNT_W-1:0] valid_count_o;
  logic [15:0] prof [16];
  logic [7:0] exp_q [$];
  logic [31:0] seed = 32'h00013D2A;
  int num_errors = 0, tests_run = 0, cycles = 0;
  always #2.5 clock_i = ~clock_i;
  debug_compare_trace_regs u_dut (
    .clock_i(clock_i), .rst_i(rst_i), .clk_en_i(clk_en_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .serial_access_i(serial_access_i), .reg_rdata_o(reg_rdata_o),
    .secure_i(secure_i), .cpu_addr_i(cpu_addr_i), .cpu_data_i(cpu_data_i), .cpu_valid_i(cpu_valid_i),
    .cpu_read_i(cpu_read_i), .opcode_fetch_i(opcode_fetch_i), .trigger_mode_i(trigger_mode_i),
    .begin_trace_i(begin_trace_i), .opcode_qualified_trigger_i(opcode_qualified_trigger_i),
    .armed_flag_o(armed_flag_o),
    .valid_count_o(valid_count_o), .break_request_o(break_request_o), .break_tag_o(break_tag_o),
    .mcu_reset_o(mcu_reset_o)
  );
  cpu_bus_model u_cpu (
    .clock_i(clock_i), .mode_i(cpu_mode), .addr_i(sel_addr), .read_i(sel_rd), .cpu_addr_o(cpu_addr_i),
    .cpu_data_o(cpu_data_i), .cpu_valid_o(cpu_valid_i), .cpu_read_o(cpu_read_i), .opcode_fetch_o(opcode_fetch_i)
  );
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic test_done();
    $display("checks %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done
  task automatic wr(input logic [3:0] ad, input logic [7:0] d, input logic ser);
    @(negedge clock_i);
    reg_addr_i = ad;
    reg_wdata_i = d;
    serial_access_i = ser;
    reg_wr_i = 1'b1;
    @(negedge clock_i);
    reg_wr_i = 1'b0;
    serial_access_i = 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] ad, input logic [7:0] e);
    @(negedge clock_i);
    reg_addr_i = ad;
    reg_rd_i = 1'b1;
    exp_q.push_back(e);
    @(negedge clock_i);
    reg_rd_i = 1'b0;
  endtask : rd
  task automatic wait_brk(input logic tag);
    int n;
    n = 0;
    while (break_request_o !== 1'b1 && n < 200) begin
      @(negedge clock_i);
      n++;
    end
    check(break_request_o, 1'b1);
    check(break_tag_o, tag);
  endtask : wait_brk
  // read data lands on the edge that samples the strobe, so look half a cycle later
  always @(posedge clock_i) rd_pend <= reg_rd_i;
  always @(negedge clock_i) begin
    if (rd_pend) check(reg_rdata_o, exp_q.pop_front());
  end
  always @(posedge clock_i) begin
    cycles++;
    if (cycles > 20000) begin
      num_errors++;
      test_done();
    end
  end
  initial begin
    repeat (16) @(posedge clock_i);
    @(negedge clock_i);
    rst_i = 1'b0;
    for (int i = 0; i < 10; i++) if (i != 5) rd(4'(i), 8'h00);
    for (int i = 0; i < 4; i++) begin
      a = 16'(rnd());
      wr(4'(i), a[7:0], 1'b0);
      rd(4'(i), a[7:0]);
    end
    a = 16'(rnd());
    wr(OFF_DEBUG_CONTROL, {2'h0, a[5:0]}, 1'b0);
    rd(OFF_DEBUG_CONTROL, {2'h0, a[5:0]});
    secure_i = 1'b1;
    wr(OFF_DEBUG_CONTROL, 8'h80, 1'b0);
    rd(OFF_DEBUG_CONTROL, 8'h00);
    secure_i = 1'b0;
    // one fetch per sample; bus idles during reads so the captured address is unambiguous
    for (int i = 0; i < 16; i++) begin
      prof[i] = 16'(rnd());
      sel_addr = prof[i];
      sel_rd = 1'b1;
      cpu_mode = 2'h2;
      @(negedge clock_i);
      cpu_mode = 2'h0;
      a = (i < 8) ? 16'h0000 : prof[i - 8];
      if (i == 4) wr(OFF_TRACE_LOW, 8'hFF, 1'b0);
      if (i == 5) wr(OFF_TRACE_HIGH, 8'hFF, 1'b0);
      rd(OFF_TRACE_HIGH, a[15:8]);
      rd(OFF_TRACE_HIGH, a[15:8]);
      rd(OFF_TRACE_LOW, a[7:0]);
    end
    for (int m = 3; m < 5; m++) begin
      trigger_mode_i = 4'(m);
      rd(OFF_TRACE_HIGH, 8'h00);
    end
    trigger_mode_i = TRG_A_ONLY;
    wr(OFF_CMP_A_HIGH, 8'h12, 1'b0);
    wr(OFF_CMP_A_LOW, 8'h34, 1'b0);
    wr(OFF_DEBUG_CONTROL, 8'hF0, 1'b0);
    wr(OFF_CMP_A_HIGH, 8'hFF, 1'b0);
    rd(OFF_CMP_A_HIGH, 8'h12);
    rd(OFF_DEBUG_CONTROL, 8'hF0);
    sel_addr = 16'h1234;
    cpu_mode = 2'h2;
    wait_brk(1'b1);
    check(armed_flag_o, 1'b0);
    sel_rd = 1'b0;
    wr(OFF_DEBUG_CONTROL, 8'hDC, 1'b0);
    repeat (20) @(negedge clock_i);
    check(armed_flag_o, 1'b1);
    sel_rd = 1'b1;
    wait_brk(1'b0);
    // qualified trigger: write cycles at the compare address must not fire
    opcode_qualified_trigger_i = 1'b1;
    sel_rd = 1'b0;
    wr(OFF_DEBUG_CONTROL, 8'hD0, 1'b0);
    repeat (10) @(negedge clock_i);
    check(armed_flag_o, 1'b1);
    sel_rd = 1'b1;
    wait_brk(1'b0);
    opcode_qualified_trigger_i = 1'b0;
    cpu_mode = 2'h0;
    begin_trace_i = 1'b1;
    wr(OFF_DEBUG_CONTROL, 8'hD0, 1'b0);
    cpu_mode = 2'h2;
    @(negedge clock_i);
    cpu_mode = 2'h1;
    wait_brk(1'b0);
    check(valid_count_o, CNT_FULL);
    begin_trace_i = 1'b0;
    cpu_mode = 2'h0;
    wr(OFF_DEBUG_CONTROL, 8'hC0, 1'b0);
    check(armed_flag_o, 1'b1);
    wr(OFF_DEBUG_CONTROL, 8'h80, 1'b0);
    check(armed_flag_o, 1'b0);
    // frozen clock enable must swallow the write
    clk_en_i = 1'b0;
    wr(OFF_CMP_A_HIGH, 8'hA5, 1'b0);
    clk_en_i = 1'b1;
    rd(OFF_CMP_A_HIGH, 8'h12);
    trigger_mode_i = TRG_EVENT_B;
    wr(OFF_CMP_B_HIGH, 8'h56, 1'b0);
    wr(OFF_CMP_B_LOW, 8'h78, 1'b0);
    sel_addr = 16'h5678;
    sel_rd = 1'b0;
    cpu_mode = 2'h2;
    wr(OFF_DEBUG_CONTROL, 8'hD3, 1'b0);
    repeat (10) @(negedge clock_i);
    check(armed_flag_o, 1'b1);
    sel_rd = 1'b1;
    wait_brk(1'b0);
    check(valid_count_o, CNT_FULL);
    cpu_mode = 2'h0;
    // model data is the address low byte xor 5A
    for (int i = 0; i < 8; i++) rd(OFF_TRACE_LOW, 8'h78 ^ 8'h5A);
    trigger_mode_i = TRG_A_ONLY;
    wr(OFF_FORCE_RESET, 8'h01, 1'b0);
    check(mcu_reset_o, 1'b0);
    wr(OFF_FORCE_RESET, 8'h01, 1'b1);
    check(mcu_reset_o, 1'b1);
    rd(OFF_FORCE_RESET, 8'h00);
    repeat (4) @(negedge clock_i);
    test_done();
  end
endmodule : debug_compare_trace_regs_tb
